/* core/ppmc_top.sv */
// Notes on behaviour
// - Writing one to bit 10 of register 1Fh enables power-saving mode.
// - Power-saving with auto-negotiation and no link turns off only the receive blocks.
// - Power-saving mode is off after power-up.
// - Zero in bit 11 of register 18h enables energy-detect power-down; one disables.
// - Energy-detect power-down without link turns off only the receive blocks and PLL.
// - Energy-detect power-down stretches link pulse spacing but keeps pulsing.
// - Energy-detect power-down is off after power-up.
// - Writing one to bit 11 of register 0h enters power-down.
// - Power-down stops core, transmitter, energy detection, PLL and receive blocks, not the management interface.
// - Writing zero to bit 11 of register 0h leaves power-down.
// - Bit 5 of register 11h drops the reference clock for the slow oscillator.
// - Slow oscillator plus power-down is the lowest state, management still alive.
// - The software reset bit clears itself.
// - Reset out of power-down needs two writes; second resets and relatches straps.
// - Bit 12 of register 0h enables auto-negotiation; power-saving and energy-detect power-down need it.
`timescale 1ns/1ps
`default_nettype none
module ppmc_top
   import ppmc_pkg::*;
#(
   parameter int unsigned NLP_CYC_P = NLP_CYC,
   parameter int unsigned EDPD_NLP_CYC_P = EDPD_NLP_CYC,
   parameter int unsigned WAKE_CYC_P = WAKE_CYC
) (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Management serial pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_out,
   // Straps
   input wire logic [2:0] phy_addr_strap_in,
   input wire logic [3:0] mode_strap_in,
   // Line status
   input wire logic link_up_in,
   input wire logic energy_in,
   // Power and clock controls
   output logic core_en_out,
   output logic tx_en_out,
   output logic energy_det_en_out,
   output logic pll_en_out,
   output logic rx_blocks_en_out,
   output logic reference_clock_input_pin_en_out,
   output logic slow_osc_sel_out,
   // Events and status
   output logic link_pulse_out,
   output logic soft_reset_out,
   output logic an_restart_out,
   output logic an_enable_out
);
   ppmc_reg_if rif ();

   logic [15:0] basic_control;
   logic [15:0] analog_front_end_control_one;
   logic [15:0] expanded_control;
   logic [15:0] transceiver_control_two;
   logic [2:0] phy_addr;
   logic strap_pend;
   logic chip_rst;
   logic wr_bc;
   logic wr_soft;
   logic power_down;
   logic lp_cond;
   logic edpd_act;
   logic ps_act;
   logic wake;
   logic [31:0] wake_cnt;
   logic next_pll_en;
   logic next_rx_en;

   ppmc_mdio_slave u_mdio (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .mdc_in(mdc_in),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe_out(mdio_oe_out),
      .bus(rif.mgmt)
   );

   ppmc_link_pulse #(
      .NORM_CYC(NLP_CYC_P),
      .LONG_CYC(EDPD_NLP_CYC_P)
   ) u_lp (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .ce_in(ce_in),
      .run_in(tx_en_out && !link_up_in),
      .long_in(edpd_act),
      .pulse_out(link_pulse_out)
   );

   // Software reset restarts the four management registers and power outputs like power-up
   assign chip_rst = sys_rst_in || soft_reset_out;
   assign wr_bc = rif.wr_stb && rif.addr == REG_BASIC_CONTROL;
   assign wr_soft = wr_bc && rif.wdata[BC_SOFT_RESET];
   assign power_down = basic_control[BC_POWER_DOWN];
   assign rif.phy_addr = phy_addr;
   assign an_enable_out = basic_control[BC_AN_ENABLE];

   // Straps are caught the cycle after any reset ends
   always_ff @(posedge clk_in) begin
      if (chip_rst) begin
         strap_pend <= 1'b1;
      end else if (ce_in) begin
         strap_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         phy_addr <= 3'h0;
      end else if (ce_in && strap_pend) begin
         phy_addr <= phy_addr_strap_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         soft_reset_out <= 1'b0;
         an_restart_out <= 1'b0;
      end else if (ce_in) begin
         soft_reset_out <= wr_soft && !power_down;
         an_restart_out <= wr_bc && rif.wdata[BC_AN_RESTART] && !rif.wdata[BC_SOFT_RESET];
      end
   end

   always_ff @(posedge clk_in) begin
      if (chip_rst) begin
         basic_control <= BC_RESET;
      end else if (ce_in) begin
         if (strap_pend) begin
            basic_control[BC_AN_ENABLE] <= mode_strap_in[STRAP_AN];
            basic_control[BC_SPEED] <= mode_strap_in[STRAP_SPEED];
            basic_control[BC_ISOLATE] <= mode_strap_in[STRAP_ISOLATE];
            basic_control[BC_DUPLEX] <= !mode_strap_in[STRAP_DUPLEX];
         end else if (wr_soft) begin
            basic_control[BC_POWER_DOWN] <= 1'b0;
         end else if (wr_bc) begin
            basic_control <= rif.wdata & BC_RW_MASK;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (chip_rst) begin
         analog_front_end_control_one <= AFE_RESET;
      end else if (ce_in && rif.wr_stb && rif.addr == REG_AFE_ONE) begin
         analog_front_end_control_one <= rif.wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (chip_rst) begin
         expanded_control <= EXP_RESET;
      end else if (ce_in && rif.wr_stb && rif.addr == REG_EXPANDED) begin
         expanded_control <= rif.wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (chip_rst) begin
         transceiver_control_two <= X2_RESET;
      end else if (ce_in && rif.wr_stb && rif.addr == REG_XCVR_TWO) begin
         transceiver_control_two <= rif.wdata;
      end
   end

   // Reads stay served in every power state
   always_comb begin
      case (rif.addr)
         REG_BASIC_CONTROL: rif.rdata = basic_control;
         REG_AFE_ONE: rif.rdata = analog_front_end_control_one;
         REG_EXPANDED: rif.rdata = expanded_control;
         REG_XCVR_TWO: rif.rdata = transceiver_control_two;
         default: rif.rdata = 16'h0000;
      endcase
   end

   assign lp_cond = basic_control[BC_AN_ENABLE] && !link_up_in && !power_down;
   assign edpd_act = lp_cond && !expanded_control[EXP_EDPD_OFF] && !wake;
   assign ps_act = lp_cond && transceiver_control_two[X2_POWER_SAVE] && !wake && !edpd_act;

   // energy restores blocks for a while
   always_ff @(posedge clk_in) begin
      if (chip_rst) begin
         wake <= 1'b0;
         wake_cnt <= 32'h0;
      end else if (ce_in) begin
         if (energy_in && lp_cond) begin
            wake <= 1'b1;
            wake_cnt <= 32'h0;
         end else if (!lp_cond || wake_cnt >= WAKE_CYC_P - 32'h1) begin
            wake <= 1'b0;
            wake_cnt <= 32'h0;
         end else if (wake) begin
            wake_cnt <= wake_cnt + 32'h1;
         end
      end
   end

   // no PLL on the slow oscillator
   assign next_pll_en = !power_down && !edpd_act && !analog_front_end_control_one[AFE_SLOW_OSC];
   assign next_rx_en = !power_down && !edpd_act && !ps_act;

   always_ff @(posedge clk_in) begin
      if (chip_rst) begin
         core_en_out <= 1'b1;
         tx_en_out <= 1'b1;
         energy_det_en_out <= 1'b1;
         pll_en_out <= 1'b1;
         rx_blocks_en_out <= 1'b1;
         slow_osc_sel_out <= 1'b0;
         reference_clock_input_pin_en_out <= 1'b1;
      end else if (ce_in) begin
         core_en_out <= !power_down;
         tx_en_out <= !power_down;
         energy_det_en_out <= !power_down;
         pll_en_out <= next_pll_en;
         rx_blocks_en_out <= next_rx_en;
         slow_osc_sel_out <= analog_front_end_control_one[AFE_SLOW_OSC];
         reference_clock_input_pin_en_out <= !analog_front_end_control_one[AFE_SLOW_OSC];
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_reset_pulse;
      soft_reset_out ##1 !soft_reset_out;
   endsequence

   sequence s_all_off;
      !core_en_out && !tx_en_out && !energy_det_en_out && !rx_blocks_en_out && !pll_en_out;
   endsequence

   property p_ps_write;
      ce_in && rif.wr_stb && rif.addr == REG_XCVR_TWO && rif.wdata[X2_POWER_SAVE]
         |=> transceiver_control_two[X2_POWER_SAVE];
   endproperty
   a_ps_write: assert property (p_ps_write) else $error("power saving not enabled");

   property p_ps_blocks;
      ce_in && ps_act && !soft_reset_out |=> !rx_blocks_en_out && pll_en_out == $past(next_pll_en)
         && tx_en_out && energy_det_en_out;
   endproperty
   a_ps_blocks: assert property (p_ps_blocks) else $error("power saving blocks wrong");

   property p_ps_reset;
      $fell(sys_rst_in) |-> !transceiver_control_two[X2_POWER_SAVE];
   endproperty
   a_ps_reset: assert property (p_ps_reset) else $error("power saving on after reset");

   property p_edpd_write;
      ce_in && rif.wr_stb && rif.addr == REG_EXPANDED && !rif.wdata[EXP_EDPD_OFF]
         && !soft_reset_out |=> !expanded_control[EXP_EDPD_OFF];
   endproperty
   a_edpd_write: assert property (p_edpd_write) else $error("edpd not enabled");

   property p_edpd_blocks;
      ce_in && edpd_act && !soft_reset_out
         |=> !rx_blocks_en_out && !pll_en_out && tx_en_out && energy_det_en_out;
   endproperty
   a_edpd_blocks: assert property (p_edpd_blocks) else $error("edpd blocks wrong");

   property p_edpd_reset;
      $fell(sys_rst_in) |-> expanded_control[EXP_EDPD_OFF];
   endproperty
   a_edpd_reset: assert property (p_edpd_reset) else $error("edpd on after reset");

   property p_pd_enter;
      ce_in && wr_bc && rif.wdata[BC_POWER_DOWN] && !rif.wdata[BC_SOFT_RESET] && !strap_pend
         |=> power_down ##1 (!ce_in or s_all_off);
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

   property p_pd_off;
      ce_in && power_down |=> s_all_off;
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("block alive in power-down");

   property p_pd_exit;
      ce_in && wr_bc && !rif.wdata[BC_POWER_DOWN] && !strap_pend |=> !power_down;
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("power-down not left");

   property p_slow_osc;
      ce_in && analog_front_end_control_one[AFE_SLOW_OSC] && !soft_reset_out
         |=> slow_osc_sel_out && !reference_clock_input_pin_en_out && !pll_en_out;
   endproperty
   a_slow_osc: assert property (p_slow_osc) else $error("slow oscillator not selected");

   property p_lowest;
      ce_in && power_down && analog_front_end_control_one[AFE_SLOW_OSC]
         |=> s_all_off and slow_osc_sel_out;
   endproperty
   a_lowest: assert property (p_lowest) else $error("lowest state not reached");

   property p_self_clear;
      ce_in && wr_soft && !power_down |=> s_reset_pulse;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("reset bit stuck");

   property p_two_writes;
      ce_in && wr_soft && power_down |=> !power_down && !soft_reset_out;
   endproperty
   a_two_writes: assert property (p_two_writes) else $error("first reset write reset chip");

   property p_an_gate;
      ce_in && !basic_control[BC_AN_ENABLE] && !power_down |=> rx_blocks_en_out;
   endproperty
   a_an_gate: assert property (p_an_gate) else $error("idle mode without auto-neg");

   property p_wake;
      ce_in && energy_in && lp_cond && !soft_reset_out
         |=> wake ##1 (!ce_in or !lp_cond or rx_blocks_en_out);
   endproperty
   a_wake: assert property (p_wake) else $error("energy did not wake blocks");
endmodule : ppmc_top
`default_nettype wire

/* pkg/ppmc_pkg.sv */
package ppmc_pkg;
   // Register numbers on the management bus
   localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] REG_AFE_ONE = 5'h11;
   localparam logic [4:0] REG_EXPANDED = 5'h18;
   localparam logic [4:0] REG_XCVR_TWO = 5'h1f;
   // Bit positions
   localparam int BC_SOFT_RESET = 15;
   localparam int BC_SPEED = 13;
   localparam int BC_AN_ENABLE = 12;
   localparam int BC_POWER_DOWN = 11;
   localparam int BC_ISOLATE = 10;
   localparam int BC_AN_RESTART = 9;
   localparam int BC_DUPLEX = 8;
   localparam int AFE_SLOW_OSC = 5;
   localparam int EXP_EDPD_OFF = 11;
   localparam int X2_POWER_SAVE = 10;
   // Strap vector positions
   localparam int STRAP_AN = 0;
   localparam int STRAP_SPEED = 1;
   localparam int STRAP_ISOLATE = 2;
   localparam int STRAP_DUPLEX = 3;
   // Write mask and values after reset
   localparam logic [15:0] BC_RW_MASK = 16'h7d80;
   localparam logic [15:0] BC_RESET = 16'h0000;
   localparam logic [15:0] AFE_RESET = 16'h0000;
   localparam logic [15:0] EXP_RESET = 16'h0800;
   localparam logic [15:0] X2_RESET = 16'h0000;
   // Management frame
   localparam logic [5:0] PREAMBLE_ONES = 6'h20;
   localparam logic [5:0] HDR_LAST = 6'h0c;
   localparam logic [5:0] DATA_LAST = 6'h0f;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   // Timing
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned NLP_MS = 16;
   localparam int unsigned EDPD_NLP_MS = 1000;
   localparam int unsigned WAKE_MS = 100;
   localparam int unsigned NLP_CYC = CLK_HZ / 1000 * NLP_MS;
   localparam int unsigned EDPD_NLP_CYC = CLK_HZ / 1000 * EDPD_NLP_MS;
   localparam int unsigned WAKE_CYC = CLK_HZ / 1000 * WAKE_MS;
   typedef enum logic [1:0] {
      MS_PRE = 2'h0,
      MS_HDR = 2'h1,
      MS_TA = 2'h3,
      MS_DATA = 2'h2
   } ppmc_mdio_state_e;
endpackage : ppmc_pkg

/* pkg/ppmc_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ppmc_reg_if;
   logic wr_stb;
   logic [4:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [2:0] phy_addr;
   modport mgmt (output wr_stb, output addr, output wdata, input rdata, input phy_addr);
   modport regs (input wr_stb, input addr, input wdata, output rdata, output phy_addr);
endinterface : ppmc_reg_if
`default_nettype wire

/* core/ppmc_mdio_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module ppmc_mdio_slave
   import ppmc_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Serial management pins
   input wire logic mdc_in,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_out,
   // Register side
   ppmc_reg_if.mgmt bus
);
   ppmc_mdio_state_e state;
   logic mdc_q;
   logic [5:0] cnt;
   logic [11:0] hdr;
   logic [15:0] sh;
   logic rd_op;
   logic rise;
   logic [12:0] hdr_all;
   logic hit;

   assign rise = mdc_in && !mdc_q;
   assign hdr_all = {hdr, mdio_in};
   // Start bit, known opcode, and own or broadcast address
   assign hit = hdr_all[12] && (hdr_all[11:10] == OP_READ || hdr_all[11:10] == OP_WRITE)
      && hdr_all[9:8] == 2'h0 && (hdr_all[7:5] == bus.phy_addr || hdr_all[7:5] == 3'h0);

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mdc_q <= 1'b0;
      end else if (ce_in) begin
         mdc_q <= mdc_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state <= MS_PRE;
         cnt <= 6'h00;
         hdr <= 12'h000;
         sh <= 16'h0000;
         rd_op <= 1'b0;
         mdio_out <= 1'b0;
         mdio_oe_out <= 1'b0;
         bus.addr <= 5'h00;
         bus.wdata <= 16'h0000;
         bus.wr_stb <= 1'b0;
      end else if (ce_in) begin
         bus.wr_stb <= 1'b0;
         if (rise) begin
            unique case (state)
               MS_PRE: begin
                  if (mdio_in) begin
                     cnt <= (cnt == PREAMBLE_ONES) ? cnt : cnt + 6'h01;
                  end else if (cnt == PREAMBLE_ONES) begin
                     state <= MS_HDR;
                     cnt <= 6'h00;
                  end else begin
                     cnt <= 6'h00;
                  end
               end
               MS_HDR: begin
                  hdr <= hdr_all[11:0];
                  cnt <= cnt + 6'h01;
                  // Start one, opcode, address and register: thirteen bits
                  if (cnt == HDR_LAST) begin
                     cnt <= 6'h00;
                     state <= hit ? MS_TA : MS_PRE;
                     rd_op <= hdr_all[11:10] == OP_READ;
                     bus.addr <= hdr_all[4:0];
                  end
               end
               MS_TA: begin
                  cnt <= cnt + 6'h01;
                  if (cnt == 6'h00) begin
                     // Second turnaround bit is driven low on reads
                     sh <= bus.rdata;
                     mdio_out <= 1'b0;
                     mdio_oe_out <= rd_op;
                  end else begin
                     state <= MS_DATA;
                     cnt <= 6'h00;
                     mdio_out <= sh[15];
                     sh <= {sh[14:0], 1'b0};
                  end
               end
               MS_DATA: begin
                  cnt <= cnt + 6'h01;
                  mdio_out <= sh[15];
                  sh <= rd_op ? {sh[14:0], 1'b0} : {sh[14:0], mdio_in};
                  if (cnt == DATA_LAST) begin
                     state <= MS_PRE;
                     cnt <= 6'h00;
                     mdio_oe_out <= 1'b0;
                     bus.wdata <= {sh[14:0], mdio_in};
                     bus.wr_stb <= !rd_op;
                  end
               end
            endcase
         end
      end
   end
endmodule : ppmc_mdio_slave
`default_nettype wire

/* core/ppmc_link_pulse.sv */
`timescale 1ns/1ps
`default_nettype none
module ppmc_link_pulse
   import ppmc_pkg::*;
#(
   parameter int unsigned NORM_CYC = NLP_CYC,
   parameter int unsigned LONG_CYC = EDPD_NLP_CYC
) (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ce_in,
   // Control
   input wire logic run_in,
   input wire logic long_in,
   // Pulse request
   output logic pulse_out
);
   logic [31:0] cnt;
   logic [31:0] limit;

   assign limit = long_in ? LONG_CYC - 32'h1 : NORM_CYC - 32'h1;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cnt <= 32'h0;
         pulse_out <= 1'b0;
      end else if (ce_in) begin
         // Stopping waits for the enable too, so a freeze holds the count
         if (!run_in) begin
            cnt <= 32'h0;
            pulse_out <= 1'b0;
         end else begin
            pulse_out <= cnt >= limit;
            cnt <= (cnt >= limit) ? 32'h0 : cnt + 32'h1;
         end
      end
   end

   property p_long_gap;
      @(posedge clk_in) disable iff (sys_rst_in)
         pulse_out && long_in && ce_in && run_in |=> !pulse_out [*8];
   endproperty
   a_long_gap: assert property (p_long_gap) else $error("stretched pulses too close");
endmodule : ppmc_link_pulse
`default_nettype wire

/* sim/ppmc_mgmt_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ppmc_mgmt_model
   import ppmc_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Device side of the data line
   input wire logic dev_data_in,
   input wire logic dev_oe_in,
   // Management pins towards the device
   output logic mdc_out,
   output logic mdio_out
);
   logic drv_en;
   logic drv_val;

   // Pull-up holds the released line high
   assign mdio_out = dev_oe_in ? dev_data_in : (drv_en ? drv_val : 1'b1);

   initial begin
      mdc_out = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b1;
   end

   // Data moves only while the serial clock is low
   task automatic bit_cycle(input logic en, input logic v, output logic s);
      drv_en = en;
      drv_val = v;
      repeat (2) @(negedge clk_in);
      s = mdio_out;
      mdc_out = 1'b1;
      repeat (2) @(negedge clk_in);
      mdc_out = 1'b0;
   endtask : bit_cycle

   // Serial clock stands still between frames
   task automatic xfer(input logic rd, input logic [2:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
      logic [45:0] hdr;
      logic s;
      hdr = {32'hffffffff, 2'b01, (rd ? OP_READ : OP_WRITE), 2'b00, pa, ra};
      for (int i = 45; i >= 0; i--) begin
         bit_cycle(1'b1, hdr[i], s);
      end
      bit_cycle(!rd, 1'b1, s);
      bit_cycle(!rd, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_cycle(!rd, wd[i], s);
         q[i] = s;
      end
      drv_en = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask : xfer
endmodule : ppmc_mgmt_model
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ppmc_pkg::*;
;
   localparam logic [2:0] PA = 3'h5;
   logic clk_in;
   logic sys_rst_in;
   logic ce_in;
   logic link_up_in;
   logic energy_in;
   logic mdc_in;
   logic mdio_in;
   logic mdio_out;
   logic mdio_oe_out;
   logic core_en_out, tx_en_out, energy_det_en_out, pll_en_out, rx_blocks_en_out;
   logic reference_clock_input_pin_en_out, slow_osc_sel_out, link_pulse_out;
   logic soft_reset_out, an_restart_out, an_enable_out;
   logic [15:0] pw;
   logic [15:0] q;
   int fail_count = 0;
   int n_checks = 0;
   int pulse_cnt = 0;
   int srst_cnt = 0;
   int arst_cnt = 0;
   int n;
   int s0;

   assign pw = {8'h00, core_en_out, tx_en_out, energy_det_en_out, pll_en_out,
                rx_blocks_en_out, reference_clock_input_pin_en_out, slow_osc_sel_out,
                an_enable_out};

   ppmc_top #(.NLP_CYC_P(20), .EDPD_NLP_CYC_P(40), .WAKE_CYC_P(30)) ppmc_top_inst (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
      .mdc_in(mdc_in), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out),
      .phy_addr_strap_in(PA), .mode_strap_in(4'h1),
      .link_up_in(link_up_in), .energy_in(energy_in),
      .core_en_out(core_en_out), .tx_en_out(tx_en_out),
      .energy_det_en_out(energy_det_en_out), .pll_en_out(pll_en_out),
      .rx_blocks_en_out(rx_blocks_en_out),
      .reference_clock_input_pin_en_out(reference_clock_input_pin_en_out),
      .slow_osc_sel_out(slow_osc_sel_out), .link_pulse_out(link_pulse_out),
      .soft_reset_out(soft_reset_out), .an_restart_out(an_restart_out),
      .an_enable_out(an_enable_out));

   ppmc_mgmt_model ppmc_mgmt_model_inst (
      .clk_in(clk_in), .dev_data_in(mdio_out), .dev_oe_in(mdio_oe_out),
      .mdc_out(mdc_in), .mdio_out(mdio_in));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      if (link_pulse_out === 1'b1) pulse_cnt <= pulse_cnt + 1;
      if (soft_reset_out === 1'b1) srst_cnt <= srst_cnt + 1;
      if (an_restart_out === 1'b1) arst_cnt <= arst_cnt + 1;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [2:0] pa, input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] r;
      ppmc_mgmt_model_inst.xfer(1'b0, pa, ra, d, r);
   endtask : wr

   task automatic rd(input logic [4:0] ra, output logic [15:0] r);
      ppmc_mgmt_model_inst.xfer(1'b1, PA, ra, 16'h0000, r);
   endtask : rd

   task automatic count_pulses(output int cnt);
      int c0;
      c0 = pulse_cnt;
      repeat (200) @(negedge clk_in);
      cnt = pulse_cnt - c0;
   endtask : count_pulses

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // Hang guard well above the longest sequence
   initial begin
      repeat (60000) @(posedge clk_in);
      fail_count++;
      summarize();
   end

   initial begin
      sys_rst_in = 1'b1;
      ce_in = 1'b1;
      link_up_in = 1'b0;
      energy_in = 1'b0;
      repeat (4) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
      rd(REG_BASIC_CONTROL, q);
      chk("basic_control", q, 16'h1100);
      rd(REG_AFE_ONE, q);
      chk("afe_one", q, 16'h0000);
      rd(REG_EXPANDED, q);
      chk("expanded", q, 16'h0800);
      rd(REG_XCVR_TWO, q);
      chk("xcvr_two", q, 16'h0000);
      rd(5'h05, q);
      chk("unmapped", q, 16'h0000);
      chk("power", pw, 16'h00fd);
      count_pulses(n);
      chk("nlp_ok", (n >= 9 && n <= 11) ? 16'h0001 : 16'h0000, 16'h0001);
      wr(PA, REG_XCVR_TWO, 16'h0400);
      chk("power", pw, 16'h00f5);
      // Frozen enable must hold every output
      ce_in = 1'b0;
      link_up_in = 1'b1;
      repeat (3) @(negedge clk_in);
      chk("frozen", pw, 16'h00f5);
      ce_in = 1'b1;
      repeat (3) @(negedge clk_in);
      chk("power", pw, 16'h00fd);
      link_up_in = 1'b0;
      repeat (3) @(negedge clk_in);
      chk("power", pw, 16'h00f5);
      energy_in = 1'b1;
      @(negedge clk_in);
      energy_in = 1'b0;
      repeat (3) @(negedge clk_in);
      chk("power", pw, 16'h00fd);
      repeat (40) @(negedge clk_in);
      chk("power", pw, 16'h00f5);
      wr(PA, REG_BASIC_CONTROL, 16'h0100);
      chk("power", pw, 16'h00fc);
      wr(PA, REG_BASIC_CONTROL, 16'h1100);
      chk("power", pw, 16'h00f5);
      wr(3'h0, REG_XCVR_TWO, 16'h0000);
      chk("power", pw, 16'h00fd);
      wr(3'h2, REG_EXPANDED, 16'h0000);
      chk("power", pw, 16'h00fd);
      wr(PA, REG_EXPANDED, 16'h0000);
      chk("power", pw, 16'h00e5);
      count_pulses(n);
      chk("edpd_ok", (n >= 4 && n <= 6) ? 16'h0001 : 16'h0000, 16'h0001);
      wr(PA, REG_EXPANDED, 16'h0800);
      chk("power", pw, 16'h00fd);
      wr(PA, REG_BASIC_CONTROL, 16'h1900);
      chk("power", pw, 16'h0005);
      count_pulses(n);
      chk("pd_pulses", n[15:0], 16'h0000);
      wr(PA, REG_AFE_ONE, 16'h0020);
      chk("power", pw, 16'h0003);
      rd(REG_BASIC_CONTROL, q);
      chk("basic_control", q, 16'h1900);
      wr(PA, REG_AFE_ONE, 16'h0000);
      chk("power", pw, 16'h0005);
      wr(PA, REG_BASIC_CONTROL, 16'h1100);
      chk("power", pw, 16'h00fd);
      s0 = srst_cnt;
      wr(PA, REG_BASIC_CONTROL, 16'h9100);
      chk("soft_resets", 16'(srst_cnt - s0), 16'h0001);
      rd(REG_BASIC_CONTROL, q);
      chk("basic_control", q, 16'h1100);
      s0 = arst_cnt;
      wr(PA, REG_BASIC_CONTROL, 16'h1300);
      chk("an_restarts", 16'(arst_cnt - s0), 16'h0001);
      rd(REG_BASIC_CONTROL, q);
      chk("basic_control", q, 16'h1100);
      wr(PA, REG_BASIC_CONTROL, 16'h1900);
      wr(PA, REG_AFE_ONE, 16'h0001);
      s0 = srst_cnt;
      wr(PA, REG_BASIC_CONTROL, 16'h9900);
      chk("power", pw, 16'h00fd);
      chk("soft_resets", 16'(srst_cnt - s0), 16'h0000);
      wr(PA, REG_BASIC_CONTROL, 16'h9100);
      chk("soft_resets", 16'(srst_cnt - s0), 16'h0001);
      rd(REG_AFE_ONE, q);
      chk("afe_one", q, 16'h0000);
      summarize();
   end
endmodule : testbench
`default_nettype wire
